// [core/cox_pkg.sv]
/*
  Constants, types and carriers for the single-channel current output
  interface: backplane offsets, status word fields, scaling and timing.
  Assumes a 125 MHz clock and a com unit that forwards MODBUS requests.
*/
package cox_pkg;

  // Clock and times (microseconds as printed).
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned EXCH_US = 6500;
  localparam int unsigned CONV_US = 50000;
  localparam int unsigned WDOG_US = 500000;
  localparam int unsigned EXCH_CYC = EXCH_US * CLK_MHZ;
  localparam int unsigned CONV_CYC = CONV_US * CLK_MHZ;
  localparam int unsigned WDOG_CYC = WDOG_US * CLK_MHZ;
  localparam logic [1:0] FAIL_LIMIT = 2'h3;

  // Function codes.
  localparam logic [7:0] FC_READ_BITS = 8'h02;
  localparam logic [7:0] FC_READ_HOLD = 8'h03;
  localparam logic [7:0] FC_READ_INPUT = 8'h04;
  localparam logic [7:0] FC_WRITE_ONE = 8'h06;
  localparam logic [7:0] FC_WRITE_MANY = 8'h10;

  // Direct offsets and legacy numbering bases.
  localparam logic [15:0] OFS_PROCESS = 16'h0100;
  localparam logic [15:0] OFS_STATUS = 16'h0300;
  localparam logic [15:0] OFS_TYPE = 16'h0400;
  localparam logic [15:0] OFS_AUX = 16'h0800;
  localparam logic [15:0] OFS_STATUS_BITS = 16'h0800;
  localparam logic [15:0] MC_ALLOC = 16'h9c41;
  localparam logic [15:0] MC_PROCESS = 16'hafc8;
  localparam logic [15:0] MC_STATUS_BITS = 16'h36b1;
  localparam logic [15:0] MC_STATUS = 16'h8980;
  localparam logic [15:0] MC_TYPE = 16'h89e4;
  localparam logic [15:0] MC_AUX = 16'h8b74;
  localparam logic [15:0] AUX_STRIDE = 16'h000c;
  localparam logic [15:0] BIT_STRIDE = 16'h0008;

  // Output word fields and scaling window.
  localparam int unsigned FLD_INVALID = 1;
  localparam int unsigned FLD_VALUE_LSB = 4;
  localparam logic [15:0] SCALE_MIN = 16'h2710;
  localparam logic [15:0] SCALE_MAX = 16'hc350;

  // Converter: 12-bit code over 0 to 25 mA; word points per mA is 2500.
  localparam int unsigned DAC_STEPS = 4096;
  localparam int unsigned FULL_UA = 25000;
  localparam int unsigned MIN_UA = 1000;
  localparam int unsigned BREAK_UA = 100;
  localparam int unsigned POINTS_PER_MA = 2500;
  localparam logic [11:0] DAC_MIN =
    12'((MIN_UA * DAC_STEPS + FULL_UA - 1) / FULL_UA);
  localparam logic [11:0] BREAK_CODE =
    12'((BREAK_UA * DAC_STEPS + FULL_UA - 1) / FULL_UA);
  localparam longint unsigned GAIN_WIDE =
    (longint'(1) << 20) * DAC_STEPS / (POINTS_PER_MA * (FULL_UA / 1000));
  localparam logic [16:0] GAIN = 17'(GAIN_WIDE);

  // Module status word fields (high byte).
  localparam int unsigned ST_LEAD = 8;
  localparam int unsigned ST_WDOG = 9;
  localparam int unsigned ST_INVALID = 10;
  localparam int unsigned ST_BUSY = 11;

  typedef enum logic [1:0] {
    ERR_CURRENT = 2'h0,
    ERR_SUBST = 2'h1,
    ERR_LAST = 2'h2
  } cox_err_mode_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_CONVERT = 2'h1,
    ST_OFF = 2'h3
  } cox_state_type;

  typedef struct packed {
    logic legacy;
    logic [7:0] fc;
    logic [15:0] addr;
    logic [15:0] data;
  } cox_req_type;

  typedef struct packed {
    logic ok;
    logic [15:0] data;
  } cox_rsp_type;

endpackage : cox_pkg

// [core/cox_channel.sv]
/*
  Current output channel: backplane register access, output word
  decoding, conversion delay, error modes, lead breakage and watchdog.
  Assumes one request per cycle at most from the com unit and a 12-bit
  current readback arriving from outside the clock domain.
*/
// Behaviour
// - Output current spans 0 to 25 mA from a 12-bit code.
// - 4 to 20 mA maps onto 2500 distinct command steps.
// - A new command reaches the output after about 50 ms.
// - Status is exchanged with the com unit every 6.5 ms.
// - Process data is an unsigned word from 0 to 65535.
// - One 16-bit word per channel; low 4 bits hold status.
// - Scaling outside 10000 to 50000 drops the status bits.
// - Bit 1 flags invalid; bits 4 to 15 carry the value.
// - Status bits read with code 2 at 2048 + 8*slot + bit.
// - Status word at 768+slot, type at 1024+slot, code 4.
// - Auxiliary block at 2048 + 12*slot, read with code 4.
// - Process word at 256+slot, written by 6 or 16, read by 3.
// - Addresses accepted in direct or legacy PLC numbering.
// - Lead-breakage detection can be disabled for the channel.
// - With detection on, at least 1 mA flows, except from reset or a watchdog switch-off until the next conversion completes.
// - Readback below 0.1 mA reports a lead breakage.
// - Three failed exchanges then 500 ms switches the output off.
// - Last-valid mode keeps the last valid value after a fault.
// - Line faults never start the substitute value strategy.
`timescale 1ns/1ps
module cox_channel #(
  parameter int unsigned EXCH_CYC = cox_pkg::EXCH_CYC,
  parameter int unsigned CONV_CYC = cox_pkg::CONV_CYC,
  parameter int unsigned WDOG_CYC = cox_pkg::WDOG_CYC,
  parameter logic [15:0] TYPE_ID = 16'h00a5, // Arbitrary value.
  parameter logic AUX_PRESENT = 1'b0
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Slot strap and channel configuration
  input wire logic [7:0] slot,
  input wire logic lf_enable,
  input wire cox_pkg::cox_err_mode_type err_mode,
  input wire logic [15:0] subst_word,
  input wire logic [15:0] scale_lo,
  input wire logic [15:0] scale_hi,
  // Com unit request and answer
  input wire logic req_valid,
  input wire cox_pkg::cox_req_type req,
  output logic rsp_valid,
  output cox_pkg::cox_rsp_type rsp,
  // Periodic status exchange
  output logic status_valid,
  output logic [15:0] status_word,
  // Converter and readback
  input wire logic [11:0] meas_code,
  output logic [11:0] dac_code,
  output logic out_enable,
  output logic lead_break
);

  cox_pkg::cox_state_type state_q, state_d;
  logic [7:0] slot_q;
  logic [15:0] word_q, last_q;
  logic [11:0] meas_s1_q, meas_s2_q, pend_q, dac_q;
  logic [25:0] exch_cnt_q, conv_cnt_q, wdog_cnt_q;
  logic [1:0] fail_q;
  logic seen_q, off_q, lead_q, out_en_q, stat_v_q, rsp_v_q;
  logic [15:0] stat_q;
  cox_pkg::cox_rsp_type rsp_q;

  // Legacy numbering is folded back onto direct offsets.
  wire logic [15:0] a = req.addr;
  wire logic is_fc2 = req.fc == cox_pkg::FC_READ_BITS;
  wire logic is_fc3 = req.fc == cox_pkg::FC_READ_HOLD;
  wire logic is_fc4 = req.fc == cox_pkg::FC_READ_INPUT;
  wire logic is_wr = req.fc == cox_pkg::FC_WRITE_ONE ||
                     req.fc == cox_pkg::FC_WRITE_MANY;
  wire logic [15:0] mc_aux = a - cox_pkg::MC_AUX + cox_pkg::OFS_AUX;
  wire logic [15:0] mc_type = a - cox_pkg::MC_TYPE + cox_pkg::OFS_TYPE;
  wire logic [15:0] mc_stat = a - cox_pkg::MC_STATUS + cox_pkg::OFS_STATUS;
  wire logic [15:0] mc_in = (a >= cox_pkg::MC_AUX) ? mc_aux :
                            (a >= cox_pkg::MC_TYPE) ? mc_type : mc_stat;
  wire logic [15:0] mc_bits =
    a - cox_pkg::MC_STATUS_BITS + cox_pkg::OFS_STATUS_BITS;
  wire logic [15:0] mc_proc = a - cox_pkg::MC_PROCESS + cox_pkg::OFS_PROCESS;
  wire logic [15:0] da = !req.legacy ? a : is_fc4 ? mc_in :
                         is_fc2 ? mc_bits : mc_proc;
  wire logic [15:0] slot16 = {8'h00, slot_q};
  wire logic [15:0] aux_base = cox_pkg::OFS_AUX +
                               16'(slot16 * cox_pkg::AUX_STRIDE);
  wire logic [15:0] bit_base = cox_pkg::OFS_STATUS_BITS +
                               16'(slot16 * cox_pkg::BIT_STRIDE);
  wire logic [15:0] bit_idx = da - bit_base;
  wire logic hit_proc = da == cox_pkg::OFS_PROCESS + slot16;
  wire logic hit_stat = da == cox_pkg::OFS_STATUS + slot16;
  wire logic hit_type = da == cox_pkg::OFS_TYPE + slot16;
  wire logic hit_aux = AUX_PRESENT && da >= aux_base &&
                       da < aux_base + cox_pkg::AUX_STRIDE;
  wire logic hit_bit = da >= bit_base && bit_idx < cox_pkg::BIT_STRIDE;
  wire logic do_write = req_valid && is_wr && hit_proc;
  // Only the output word is writable; there are no input data words.
  wire logic req_ok = (is_wr || is_fc3) && hit_proc ||
                      is_fc4 && (hit_stat || hit_type || hit_aux) ||
                      is_fc2 && hit_bit;
  wire logic [15:0] rd_bit = {15'h0,
                              stat_q[cox_pkg::ST_LEAD + bit_idx[2:0]]};
  wire logic [15:0] rd_data = !req_ok ? 16'h0000 :
                              is_fc2 ? rd_bit :
                              (is_fc3 || is_wr) ? word_q :
                              hit_stat ? stat_q :
                              hit_type ? TYPE_ID : 16'h0000;

  // Output word decoding and scaling to the converter code.
  wire logic status_on = scale_lo >= cox_pkg::SCALE_MIN &&
                         scale_hi <= cox_pkg::SCALE_MAX;
  wire logic invalid = status_on && word_q[cox_pkg::FLD_INVALID];
  wire cox_pkg::cox_err_mode_type mode = err_mode;
  wire logic [15:0] err_word = mode == cox_pkg::ERR_SUBST ? subst_word :
                               mode == cox_pkg::ERR_LAST ? last_q :
                               word_q;
  // A line fault is not an error here, only invalid data is.
  wire logic [15:0] use_word = invalid ? err_word : word_q;
  wire logic use_status = status_on && !(invalid && mode == cox_pkg::ERR_SUBST);
  wire logic [15:0] val_word = use_status ?
    {use_word[15:cox_pkg::FLD_VALUE_LSB], 4'h0} : use_word;
  wire logic [32:0] prod = val_word * cox_pkg::GAIN;
  wire logic [12:0] code_w = prod[32:20];
  wire logic [11:0] code_sat = code_w[12] ? 12'hfff : code_w[11:0];
  wire logic [11:0] target = (lf_enable && code_sat < cox_pkg::DAC_MIN) ?
                             cox_pkg::DAC_MIN : code_sat;

  // Period tick, exchange bookkeeping and watchdog.
  wire logic tick = exch_cnt_q == 26'(EXCH_CYC - 1);
  wire logic exch_ok = seen_q || req_valid;
  wire logic recover = tick && exch_ok;
  wire logic wdog_run = fail_q == cox_pkg::FAIL_LIMIT && !off_q;
  wire logic wdog_done = wdog_run && wdog_cnt_q == 26'(WDOG_CYC - 1);
  wire logic conv_done = conv_cnt_q == 26'(CONV_CYC - 1);
  wire logic broken = lf_enable && meas_s2_q < cox_pkg::BREAK_CODE;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      cox_pkg::ST_IDLE: begin
        if (off_q) begin
          state_d = cox_pkg::ST_OFF;
        end else if (target != dac_q) begin
          state_d = cox_pkg::ST_CONVERT;
        end
      end
      cox_pkg::ST_CONVERT: begin
        if (off_q) begin
          state_d = cox_pkg::ST_OFF;
        end else if (conv_done) begin
          state_d = cox_pkg::ST_IDLE;
        end
      end
      cox_pkg::ST_OFF: begin
        if (!off_q) begin
          state_d = cox_pkg::ST_IDLE;
        end
      end
      default: state_d = cox_pkg::ST_OFF;
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      slot_q <= slot;
      word_q <= 16'h0000;
      last_q <= 16'h0000;
      rsp_v_q <= 1'b0;
      rsp_q <= '0;
    end else begin
      rsp_v_q <= req_valid;
      rsp_q <= '{ok: req_ok, data: rd_data};
      if (do_write) begin
        word_q <= req.data;
      end
      if (!invalid) begin
        last_q <= word_q;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      exch_cnt_q <= 26'h0000000;
      seen_q <= 1'b0;
      fail_q <= 2'h0;
      wdog_cnt_q <= 26'h0000000;
      off_q <= 1'b0;
    end else begin
      exch_cnt_q <= tick ? 26'h0000000 : exch_cnt_q + 26'h0000001;
      seen_q <= req_valid || (seen_q && !tick);
      // A timeout in the same cycle as a good exchange wins, so the fail
      // count is kept and the output stays off until the next good one.
      if (tick) begin
        fail_q <= (exch_ok && !wdog_done) ? 2'h0 :
                  (fail_q == cox_pkg::FAIL_LIMIT ? fail_q : fail_q + 2'h1);
      end
      wdog_cnt_q <= wdog_run ? wdog_cnt_q + 26'h0000001 : 26'h0000000;
      if (wdog_done) begin
        off_q <= 1'b1;
      end else if (recover || fail_q != cox_pkg::FAIL_LIMIT) begin
        off_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_q <= cox_pkg::ST_IDLE;
      conv_cnt_q <= 26'h0000000;
      pend_q <= 12'h000;
      dac_q <= 12'h000;
      out_en_q <= 1'b0;
    end else begin
      state_q <= state_d;
      conv_cnt_q <= (state_q == cox_pkg::ST_CONVERT && !conv_done) ?
                    conv_cnt_q + 26'h0000001 : 26'h0000000;
      if (state_q == cox_pkg::ST_IDLE) begin
        pend_q <= target;
      end
      if (state_q == cox_pkg::ST_CONVERT && conv_done && !off_q) begin
        dac_q <= pend_q;
      end else if (off_q) begin
        dac_q <= 12'h000;
      end
      out_en_q <= !off_q;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      meas_s1_q <= 12'h000;
      meas_s2_q <= 12'h000;
      lead_q <= 1'b0;
      stat_q <= 16'h0000;
      stat_v_q <= 1'b0;
    end else begin
      meas_s1_q <= meas_code;
      meas_s2_q <= meas_s1_q;
      lead_q <= broken;
      stat_q <= {4'h0, state_q == cox_pkg::ST_CONVERT, invalid, off_q,
                 lead_q, 8'h00};
      stat_v_q <= tick;
    end
  end

  assign rsp_valid = rsp_v_q;
  assign rsp = rsp_q;
  assign status_valid = stat_v_q;
  assign status_word = stat_q;
  assign dac_code = dac_q;
  assign out_enable = out_en_q;
  assign lead_break = lead_q;

  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  chk_status_period: assert property (
    status_valid |=> !status_valid [*8])
    else $error("status pulses closer than period");
  chk_watchdog_off: assert property (
    wdog_done |=> ##1 !out_enable && dac_code == 12'h000)
    else $error("output not switched off after watchdog");
  chk_fail_needs_three: assert property (
    off_q |-> fail_q == cox_pkg::FAIL_LIMIT)
    else $error("output off before three failed exchanges");
  chk_conv_delay: assert property (
    $changed(dac_q) && !off_q |-> $past(conv_done))
    else $error("command applied without conversion delay");
  chk_min_current: assert property (
    lf_enable && !off_q |-> target >= cox_pkg::DAC_MIN)
    else $error("current below 1 mA with detection on");
  chk_lead_report: assert property (
    lf_enable && meas_s2_q < cox_pkg::BREAK_CODE ##1 lf_enable |-> lead_break)
    else $error("lead breakage not reported");
  chk_lead_disabled: assert property (
    !lf_enable ##1 1'b1 |-> !lead_break)
    else $error("lead breakage reported while disabled");
  chk_write_store: assert property (
    do_write |=> word_q == $past(req.data))
    else $error("output word write lost");
  chk_rsp_timing: assert property (
    req_valid |=> rsp_valid)
    else $error("answer not one cycle after request");
  chk_low_bits_drop: assert property (
    use_status |-> val_word[3:0] == 4'h0)
    else $error("status bits reach the converter");
  chk_subst_line: assert property (
    !invalid |-> use_word == word_q)
    else $error("line fault changed the output value");

  cov_write: cover property (do_write ##1 state_q == cox_pkg::ST_CONVERT);
  cov_off: cover property (wdog_done);
  cov_invalid: cover property (invalid && mode == cox_pkg::ERR_LAST);
  cov_break: cover property (lead_break);

endmodule : cox_channel

// [sim/cox_com_model.sv]
/*
  Com unit model: forwards bench requests one at a time and, while keep
  is high, polls the module status often enough to hold off the watchdog.
  Assumes the channel answers exactly one clock after each request.
*/
`timescale 1ns/1ps
module cox_com_model #(
  parameter int unsigned GAP = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Bench side
  input wire logic [7:0] slot,
  input wire logic go,
  input wire cox_pkg::cox_req_type cmd,
  input wire logic keep,
  output logic done,
  output cox_pkg::cox_rsp_type got,
  // Channel side
  output logic req_valid,
  output cox_pkg::cox_req_type req,
  input wire logic rsp_valid,
  input wire cox_pkg::cox_rsp_type rsp
);
  logic pend_q, busy_q, mine_q;
  logic [7:0] gap_q;
  cox_pkg::cox_req_type cmd_q, poll;
  assign poll = {1'b0, cox_pkg::FC_READ_INPUT,
    16'(cox_pkg::OFS_STATUS + 16'(slot)), 16'h0000};
  always_ff @(posedge clock) begin
    req_valid <= 1'b0;
    done <= 1'b0;
    // Idle request lines toggle so a stale value is never read as valid.
    req <= ~req;
    gap_q <= gap_q + 8'h01;
    if (go) begin
      pend_q <= 1'b1;
      cmd_q <= cmd;
    end
    if (busy_q && rsp_valid) begin
      busy_q <= 1'b0;
      done <= mine_q;
      if (mine_q) got <= rsp;
    end else if (!busy_q && pend_q) begin
      req_valid <= 1'b1;
      req <= cmd_q;
      pend_q <= 1'b0;
      mine_q <= 1'b1;
      busy_q <= 1'b1;
    end else if (!busy_q && keep && gap_q >= 8'(GAP)) begin
      req_valid <= 1'b1;
      req <= poll;
      gap_q <= 8'h00;
      mine_q <= 1'b0;
      busy_q <= 1'b1;
    end
    if (reset) begin
      {req_valid, done, pend_q, busy_q, mine_q} <= 5'h00;
      gap_q <= 8'h00;
      got <= '0;
      req <= '0;
      cmd_q <= '0;
    end
  end
endmodule : cox_com_model

// [sim/cox_channel_test.sv]
/*
  Self-checking bench for the current output channel with shortened
  periods. Assumes the com unit model in cox_com_model.
*/
`timescale 1ns/1ps
module cox_channel_test;
  localparam int unsigned EXCH = 20;
  localparam int unsigned WDOG = 50;
  localparam logic [15:0] TID = 16'h005a; // Arbitrary value.
  logic clock = 1'b0, reset = 1'b1, lf_enable = 1'b1, go = 1'b0;
  logic keep = 1'b1, done, req_valid, rsp_valid, status_valid;
  logic out_enable, lead_break;
  logic [7:0] slot = 8'h03;
  cox_pkg::cox_err_mode_type err_mode = cox_pkg::ERR_CURRENT;
  logic [15:0] subst_word = 16'h0000, scale_lo = 16'h2710;
  logic [15:0] scale_hi = 16'hc350, status_word;
  cox_pkg::cox_req_type req, cmd = '0;
  cox_pkg::cox_rsp_type rsp, got;
  logic [11:0] meas_code = 12'h0c8, dac_code;
  int miscompares = 0, tests_run = 0, n;
  always #4 clock = ~clock;
  cox_channel #(.EXCH_CYC(EXCH), .CONV_CYC(10), .WDOG_CYC(WDOG),
    .TYPE_ID(TID)) uut (.clock(clock), .reset(reset), .slot(slot),
    .lf_enable(lf_enable), .err_mode(err_mode), .subst_word(subst_word),
    .scale_lo(scale_lo), .scale_hi(scale_hi), .req_valid(req_valid),
    .req(req), .rsp_valid(rsp_valid), .rsp(rsp),
    .status_valid(status_valid), .status_word(status_word),
    .meas_code(meas_code), .dac_code(dac_code), .out_enable(out_enable),
    .lead_break(lead_break));
  cox_com_model com (.clock(clock), .reset(reset), .slot(slot), .go(go),
    .cmd(cmd), .keep(keep), .done(done), .got(got),
    .req_valid(req_valid), .req(req), .rsp_valid(rsp_valid), .rsp(rsp));
  task automatic step(input int c);
    repeat (c) @(posedge clock);
    #1;
  endtask : step
  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [16:0] a, input logic [16:0] e);
    tests_run++;
    if (a !== e) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, a, e);
    end
  endtask : chk
  task automatic access(input logic lg, input logic [7:0] fc,
    input logic [15:0] ad, input logic [15:0] d);
    cmd = {lg, fc, ad, d};
    go = 1'b1;
    step(1);
    go = 1'b0;
    for (n = 0; n < 20 && done !== 1'b1; n++) step(1);
    if (n == 20) begin
      miscompares++;
      complete_run();
    end
  endtask : access
  task automatic t_regs;
    access(1, cox_pkg::FC_WRITE_MANY, 16'hafc8 + 16'(slot), 16'h4e20);
    access(0, cox_pkg::FC_READ_HOLD, 16'h0100 + 16'(slot), 16'h0000);
    chk(got, {1'b1, 16'h4e20});
    access(0, cox_pkg::FC_WRITE_ONE, 16'h0100 + 16'(slot), 16'h271d);
    access(1, cox_pkg::FC_READ_HOLD, 16'hafc8 + 16'(slot), 16'h0000);
    chk(got, {1'b1, 16'h271d});
    access(0, cox_pkg::FC_READ_INPUT, 16'h0400 + 16'(slot), 16'h0000);
    chk(got, {1'b1, TID});
    access(1, cox_pkg::FC_READ_INPUT, 16'h89e4 + 16'(slot), 16'h0000);
    chk(got, {1'b1, TID});
    access(0, cox_pkg::FC_READ_INPUT, 16'h0200, 16'h0000);
    chk(got, 17'h00000);
    access(0, cox_pkg::FC_READ_INPUT, 16'h0800 + 16'(slot) * 16'h000c,
      16'h0000);
    chk(got, 17'h00000);
    access(0, cox_pkg::FC_READ_BITS, 16'h0801 + 16'(slot) * 16'h0008,
      16'h0000);
    chk(got, {1'b1, 16'h0000});
  endtask : t_regs
  task automatic t_conv;
    for (n = 0; n < 60 && dac_code !== 12'h28f; n++) step(1);
    chk(17'(dac_code), 17'h0028f);
    err_mode = cox_pkg::ERR_LAST;
    access(0, cox_pkg::FC_WRITE_ONE, 16'h0100 + 16'(slot), 16'h4e22);
    step(40);
    chk(17'(dac_code), 17'h0028f);
    err_mode = cox_pkg::ERR_SUBST;
    subst_word = 16'hc350;
    step(30);
    chk(17'(dac_code), 17'h00ccc);
    access(0, cox_pkg::FC_WRITE_ONE, 16'h0100 + 16'(slot), 16'h271d);
    step(30);
  endtask : t_conv
  task automatic t_lead;
    // Substitute mode stays selected, so a line fault that started it
    // would move the converter code within this wait.
    meas_code = 12'h000;
    step(20);
    chk({15'h0, lead_break, status_word[8]}, 17'h00003);
    chk(17'(dac_code), 17'h0028f);
    access(0, cox_pkg::FC_READ_BITS, 16'h0800 + 16'(slot) * 16'h0008,
      16'h0000);
    chk(got, {1'b1, 16'h0001});
    lf_enable = 1'b0;
    step(4);
    chk(17'(lead_break), 17'h00000);
    lf_enable = 1'b1;
    meas_code = 12'h0c8;
    access(0, cox_pkg::FC_WRITE_ONE, 16'h0100 + 16'(slot), 16'h0000);
    step(30);
    chk(17'(dac_code), 17'h000a4);
  endtask : t_lead
  task automatic t_wdog;
    for (n = 0; n < 40 && status_valid !== 1'b1; n++) step(1);
    step(1);
    for (n = 1; n < 40 && status_valid !== 1'b1; n++) step(1);
    chk(17'(n), 17'(EXCH));
    keep = 1'b0;
    for (n = 0; n < 200 && out_enable !== 1'b0; n++) step(1);
    step(3);
    chk({14'h0, n > 3 * EXCH + WDOG, out_enable, status_word[9]},
      17'h00005);
    chk(17'(dac_code), 17'h00000);
    keep = 1'b1;
    step(50);
    chk({4'h0, out_enable, dac_code}, {5'h01, 12'h0a4});
  endtask : t_wdog
  initial begin
    step(20);
    reset = 1'b0;
    step(2);
    chk(17'(out_enable), 17'h00001);
    t_regs();
    t_conv();
    t_lead();
    t_wdog();
    complete_run();
  end
endmodule : cox_channel_test
